// ==== hdl/sto_pkg.sv ====
// Purpose: Shared constants and types for the safe torque off supervisor.
// Assumes: 50 MHz system clock; channel inputs high when the contact is closed.
// Notes: Times are kept in their own units; all but IND_FAULT_MAX_MS are converted to clock cycles here.
package sto_pkg;

    localparam int unsigned CLK_FREQ_MHZ = 50;

    // Drive output must be off within this time of a channel opening.
    localparam int unsigned TRIGGER_MAX_MS = 10;
    // Indication limits for the normal request and for channel faults.
    localparam int unsigned IND_STO_MAX_MS = 100;
    localparam int unsigned IND_FAULT_MAX_MS = 280;

    // Glitch filter time and two-channel agreement window.
    localparam int unsigned FILTER_TIME_US = 1000;
    localparam int unsigned DISCREP_TIME_MS = 50;

    localparam int unsigned FILTER_CYCLES = FILTER_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned DISCREP_CYCLES = DISCREP_TIME_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned TRIGGER_MAX_CYCLES = TRIGGER_MAX_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned IND_STO_MAX_CYCLES = IND_STO_MAX_MS * 1000 * CLK_FREQ_MHZ;

    localparam int unsigned CNT_W = 32;

    // Reset value of a filtered channel: open, so torque stays off until proven closed.
    localparam logic CHANNEL_RESET = 1'h0;

    // Fault reset mode for E40: manual needs a reset request, auto clears on channel closure.
    localparam logic RESET_MODE_MANUAL = 1'h0;
    localparam logic RESET_MODE_AUTO = 1'h1;

    typedef enum logic [2:0] {
        FC_NONE,
        FC_E40,
        FC_E41,
        FC_E42,
        FC_E43
    } fault_code_t;

    typedef struct packed {
        logic sto_active;
        logic torque_enable;
        fault_code_t code;
    } sto_status_t;

endpackage : sto_pkg

// ==== hdl/sto_channel_filter.sv ====
// Purpose: Synchronise one safety channel and reject short glitches.
// Assumes: Input level is asynchronous to clk_sys.
// Notes: Output changes only after the synchronised level stood for STABLE_CYCLES.
`timescale 1ns/1ps
module sto_channel_filter import sto_pkg::*; #(
    parameter int unsigned STABLE_CYCLES = FILTER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic channel_in,
    output logic channel_filt
);

    logic sync_meta;
    logic sync_level;
    logic [CNT_W-1:0] stable_cnt;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_meta <= CHANNEL_RESET;
            sync_level <= CHANNEL_RESET;
        end else begin
            sync_meta <= channel_in;
            sync_level <= sync_meta;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stable_cnt <= '0;
            channel_filt <= CHANNEL_RESET;
        end else if (sync_level == channel_filt) begin
            stable_cnt <= '0;
        end else if (stable_cnt >= CNT_W'(STABLE_CYCLES - 1)) begin
            stable_cnt <= '0;
            channel_filt <= sync_level;
        end else begin
            stable_cnt <= stable_cnt + CNT_W'(1);
        end
    end

    property p_filter_stable;
        @(posedge clk_sys) disable iff (srst)
        (channel_filt != $past(channel_filt)) |-> ($past(stable_cnt) == CNT_W'(STABLE_CYCLES - 1));
    endproperty
    a_filter_stable: assert property (p_filter_stable)
        else $error("Filtered channel changed before the stable time elapsed.");

endmodule : sto_channel_filter

// ==== hdl/safe_torque_off_monitor.sv ====
// Purpose: Two-channel safe torque off supervisor for a motor drive.
// Assumes: Channel inputs high means closed (run allowed); srst is the power-on reset.
// Notes: Single-channel faults survive everything except srst.
`timescale 1ns/1ps

module safe_torque_off_monitor import sto_pkg::*; #(
    parameter int unsigned FILTER_LEN = FILTER_CYCLES,
    parameter int unsigned DISCREP_LEN = DISCREP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic safety_channel_a,
    input wire logic safety_channel_b,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic fault_reset_req,
    input wire logic fault_reset_mode_param,
    output sto_status_t status
);

    typedef enum logic [1:0] {
        ST_RUN_OK,
        ST_CLASSIFY,
        ST_STO_NORMAL,
        ST_FAULT
    } sto_state_t;

    sto_state_t state;
    logic chan_a;
    logic chan_b;
    logic prev_a;
    logic prev_b;
    logic seen_a_open;
    logic seen_b_open;
    logic fault_a;
    logic fault_b;
    logic run_req;
    logic [CNT_W-1:0] window_cnt;
    logic window_done;
    logic pattern_change;
    logic both_closed;

    sto_channel_filter #(
        .STABLE_CYCLES(FILTER_LEN)
    ) u_filter_a (
        .clk_sys(clk_sys),
        .srst(srst),
        .channel_in(safety_channel_a),
        .channel_filt(chan_a)
    );

    sto_channel_filter #(
        .STABLE_CYCLES(FILTER_LEN)
    ) u_filter_b (
        .clk_sys(clk_sys),
        .srst(srst),
        .channel_in(safety_channel_b),
        .channel_filt(chan_b)
    );

    assign both_closed = chan_a && chan_b;
    assign pattern_change = (chan_a != prev_a) || (chan_b != prev_b);
    assign window_done = (window_cnt >= CNT_W'(DISCREP_LEN - 1));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prev_a <= CHANNEL_RESET;
            prev_b <= CHANNEL_RESET;
        end else begin
            prev_a <= chan_a;
            prev_b <= chan_b;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || state != ST_CLASSIFY || pattern_change) begin
            window_cnt <= '0;
        end else if (!window_done) begin
            window_cnt <= window_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            seen_a_open <= 1'h0;
            seen_b_open <= 1'h0;
        end else if (state != ST_CLASSIFY && pattern_change && !both_closed) begin
            seen_a_open <= !chan_a;
            seen_b_open <= !chan_b;
        end else if (state == ST_CLASSIFY) begin
            seen_a_open <= seen_a_open || (!chan_a && prev_a);
            seen_b_open <= seen_b_open || (!chan_b && prev_b);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fault_a <= 1'h0;
            fault_b <= 1'h0;
        end else if (state == ST_CLASSIFY && window_done && !(!chan_a && !chan_b)) begin
            if (!chan_a) begin
                fault_a <= 1'h1;
            end else if (!chan_b) begin
                fault_b <= 1'h1;
            end else if (seen_a_open && !seen_b_open) begin
                fault_a <= 1'h1;
            end else if (seen_b_open && !seen_a_open) begin
                fault_b <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_CLASSIFY;
        end else begin
            case (state)
                ST_RUN_OK: begin
                    if (!both_closed) begin
                        state <= ST_CLASSIFY;
                    end
                end
                ST_CLASSIFY: begin
                    if (window_done) begin
                        if (fault_a || fault_b || (chan_a != chan_b)
                                || (both_closed && seen_a_open != seen_b_open)) begin
                            state <= ST_FAULT;
                        end else if (seen_a_open || seen_b_open || !both_closed) begin
                            state <= ST_STO_NORMAL;
                        end else begin
                            state <= ST_RUN_OK;
                        end
                    end
                end
                ST_STO_NORMAL: begin
                    if (pattern_change && !both_closed) begin
                        state <= ST_CLASSIFY;
                    end else if (both_closed && (fault_reset_mode_param == RESET_MODE_AUTO
                            || fault_reset_req)) begin
                        state <= ST_RUN_OK;
                    end
                end
                ST_FAULT: begin
                    if (pattern_change && !both_closed) begin
                        state <= ST_CLASSIFY;
                    end
                end
                default: begin
                    state <= ST_CLASSIFY;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || stop_cmd || state != ST_RUN_OK || !both_closed) begin
            run_req <= 1'h0;
        end else if (start_cmd) begin
            run_req <= 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status.sto_active <= 1'h1;
            status.torque_enable <= 1'h0;
            status.code <= FC_NONE;
        end else begin
            status.sto_active <= !(state == ST_RUN_OK && both_closed);
            status.torque_enable <= state == ST_RUN_OK && both_closed && run_req;
            if (fault_a && fault_b) begin
                status.code <= FC_E43;
            end else if (fault_a) begin
                status.code <= FC_E41;
            end else if (fault_b) begin
                status.code <= FC_E42;
            end else if (state == ST_STO_NORMAL) begin
                status.code <= FC_E40;
            end else begin
                status.code <= FC_NONE;
            end
        end
    end

    sequence s_channel_opens;
        !chan_a || !chan_b;
    endsequence

    property p_torque_off;
        @(posedge clk_sys) disable iff (srst)
        s_channel_opens |=> !status.torque_enable && status.sto_active;
    endproperty
    a_torque_off: assert property (p_torque_off)
        else $error("Torque stayed enabled after a channel opened.");

    property p_start_ignored;
        @(posedge clk_sys) disable iff (srst)
        (status.sto_active && start_cmd && !both_closed) |=> ##1 !status.torque_enable;
    endproperty
    a_start_ignored: assert property (p_start_ignored)
        else $error("Start command enabled torque during safe torque off.");

    property p_run_clean;
        @(posedge clk_sys) disable iff (srst)
        (state == ST_RUN_OK && both_closed && !fault_a && !fault_b) |=> status.code == FC_NONE;
    endproperty
    a_run_clean: assert property (p_run_clean)
        else $error("Fault code shown while running normally.");

    property p_code_e40;
        @(posedge clk_sys) disable iff (srst)
        (state == ST_STO_NORMAL && !fault_a && !fault_b) |=> status.code == FC_E40;
    endproperty
    a_code_e40: assert property (p_code_e40)
        else $error("Normal safe torque off not reported as E40.");

    property p_fault_a_set;
        @(posedge clk_sys) disable iff (srst)
        (state == ST_CLASSIFY && window_done && !chan_a && chan_b && !fault_b)
            |=> fault_a ##1 status.code == FC_E41;
    endproperty
    a_fault_a_set: assert property (p_fault_a_set)
        else $error("Channel A alone open did not give E41.");

    property p_fault_b_set;
        @(posedge clk_sys) disable iff (srst)
        (state == ST_CLASSIFY && window_done && chan_a && !chan_b && !fault_a)
            |=> fault_b ##1 status.code == FC_E42;
    endproperty
    a_fault_b_set: assert property (p_fault_b_set)
        else $error("Channel B alone open did not give E42.");

    property p_both_abnormal;
        @(posedge clk_sys) disable iff (srst)
        (fault_a && fault_b) |=> status.code == FC_E43 && !status.torque_enable;
    endproperty
    a_both_abnormal: assert property (p_both_abnormal)
        else $error("Both channel faults not reported as E43.");

    property p_fault_latched;
        @(posedge clk_sys) disable iff (srst)
        (fault_a || fault_b) |=> (fault_a >= $past(fault_a)) && (fault_b >= $past(fault_b))
            && state != ST_RUN_OK;
    endproperty
    a_fault_latched: assert property (p_fault_latched)
        else $error("Latched channel fault cleared without a power cycle.");

    property p_auto_clear;
        @(posedge clk_sys) disable iff (srst)
        (state == ST_STO_NORMAL && both_closed && !pattern_change
            && fault_reset_mode_param == RESET_MODE_AUTO) |=> state == ST_RUN_OK;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("Automatic E40 reset did not clear the state.");

    property p_manual_hold;
        @(posedge clk_sys) disable iff (srst)
        (state == ST_STO_NORMAL && !fault_reset_req
            && fault_reset_mode_param == RESET_MODE_MANUAL) |=> state != ST_RUN_OK;
    endproperty
    a_manual_hold: assert property (p_manual_hold)
        else $error("Manual E40 cleared without a reset request.");

    property p_indication_bound;
        @(posedge clk_sys) disable iff (srst)
        state == ST_CLASSIFY |-> window_cnt < CNT_W'(IND_STO_MAX_CYCLES);
    endproperty
    a_indication_bound: assert property (p_indication_bound)
        else $error("Classification window exceeds the indication limit.");

    property p_trigger_bound;
        @(posedge clk_sys) disable iff (srst)
        1'h1 |-> FILTER_LEN + 4 < TRIGGER_MAX_CYCLES;
    endproperty
    a_trigger_bound: assert property (p_trigger_bound)
        else $error("Filter length exceeds the trigger limit.");

endmodule : safe_torque_off_monitor

// ==== testbench/sto_switch_model.sv ====
// Purpose: Behavioural model of the external safety switch that drives both channels.
// Assumes: The bench sets the open commands at the falling edge; a closed contact reads high.
// Notes: The lag setting delays both contacts alike, to model a slow relay.
`timescale 1ns/1ps
module sto_switch_model (
    input wire logic clk_sys,
    input wire logic open_a,
    input wire logic open_b,
    input wire logic [2:0] lag,
    output logic safety_channel_a,
    output logic safety_channel_b
);
    logic [7:0] hist_a = 8'h00;
    logic [7:0] hist_b = 8'h00;

    always @(posedge clk_sys) begin
        hist_a <= {hist_a[6:0], ~open_a};
        hist_b <= {hist_b[6:0], ~open_b};
    end

    assign safety_channel_a = hist_a[lag];
    assign safety_channel_b = hist_b[lag];
endmodule : sto_switch_model

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the safe torque off supervisor.
// Assumes: Short filter and agreement windows keep the run brief.
// Notes: A small integer model predicts the status after every step.
`timescale 1ns/1ps
module testbench import sto_pkg::*; ();
    localparam int FL = 4;
    localparam int DL = 20;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic start_cmd = 1'b0;
    logic stop_cmd = 1'b0;
    logic fault_reset_req = 1'b0;
    logic fault_reset_mode_param = 1'b0;
    logic open_a = 1'b1;
    logic open_b = 1'b1;
    logic [2:0] lag = 3'h0;
    logic safety_channel_a;
    logic safety_channel_b;
    sto_status_t status;
    int bad_count = 0;
    int num_checks = 0;
    int m_up = 0;
    int m_run = 0;
    int m_fa = 0;
    int m_fb = 0;
    int m_e40 = 0;
    int glen;

    always #10 clk_sys = ~clk_sys;

    sto_switch_model u_switch (.clk_sys(clk_sys), .open_a(open_a), .open_b(open_b), .lag(lag),
        .safety_channel_a(safety_channel_a), .safety_channel_b(safety_channel_b));

    safe_torque_off_monitor #(.FILTER_LEN(FL), .DISCREP_LEN(DL)) u_dut (.clk_sys(clk_sys),
        .srst(srst), .safety_channel_a(safety_channel_a), .safety_channel_b(safety_channel_b),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault_reset_req(fault_reset_req),
        .fault_reset_mode_param(fault_reset_mode_param), .status(status));

    function automatic sto_status_t model_status();
        sto_status_t s;
        s.torque_enable = (m_run != 0);
        s.sto_active = !(m_up != 0 && m_fa == 0 && m_fb == 0 && m_e40 == 0);
        if (m_fa != 0 && m_fb != 0) s.code = FC_E43;
        else if (m_fa != 0) s.code = FC_E41;
        else if (m_fb != 0) s.code = FC_E42;
        else if (m_e40 != 0) s.code = FC_E40;
        else s.code = FC_NONE;
        return s;
    endfunction : model_status

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    // Waits a bounded time for the predicted status, then compares.
    task automatic settle(input int lim);
        for (int i = 0; i < lim && status !== model_status(); i++) tick(1);
        chk(status, model_status());
    endtask : settle

    task automatic start_run();
        start_cmd = 1'b1;
        tick(1);
        start_cmd = 1'b0;
        if (!model_status().sto_active) m_run = 1;
        settle(6);
    endtask : start_run

    task automatic bring_up();
        open_a = 1'b0;
        open_b = 1'b0;
        m_up = 1;
        settle(FL + DL + 28);
    endtask : bring_up

    // Opens the chosen contacts, checks torque off time, tries a start, checks the code.
    task automatic open_ch(input logic a, input logic b);
        open_a = a;
        open_b = b;
        m_run = 0;
        if (a && b) m_e40 = 1;
        else if (a) m_fa = 1;
        else m_fb = 1;
        for (int i = 0; i < FL + 14 && status.torque_enable !== 1'b0; i++) tick(1);
        chk({4'h0, status.torque_enable}, 5'h00);
        start_cmd = 1'b1;
        tick(1);
        start_cmd = 1'b0;
        settle(DL + 24);
    endtask : open_ch

    task automatic power_cycle();
        srst = 1'b1;
        tick(4);
        srst = 1'b0;
        {m_up, m_run, m_fa, m_fb, m_e40} = '0;
        chk(status, model_status());
        bring_up();
    endtask : power_cycle

    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end_of_test();
    end

    initial begin
        void'($urandom(32'hf4fc));
        tick(16);
        chk(status, model_status());
        srst = 1'b0;
        bring_up();
        start_cmd = 1'b1;
        stop_cmd = 1'b1;
        tick(1);
        {start_cmd, stop_cmd} = 2'b00;
        tick(3);
        chk(status, model_status());
        start_run();
        glen = 1 + int'($urandom % (FL - 2));
        open_a = 1'b1;
        tick(glen);
        open_a = 1'b0;
        tick(FL + 10);
        chk(status, model_status());
        open_ch(1'b1, 1'b1);
        {open_a, open_b} = 2'b00;
        tick(FL + DL + 12);
        chk(status, model_status());
        fault_reset_req = 1'b1;
        tick(1);
        fault_reset_req = 1'b0;
        m_e40 = 0;
        settle(6);
        start_run();
        stop_cmd = 1'b1;
        tick(1);
        stop_cmd = 1'b0;
        m_run = 0;
        settle(6);
        start_run();
        fault_reset_mode_param = 1'b1;
        open_ch(1'b1, 1'b1);
        {open_a, open_b} = 2'b00;
        m_e40 = 0;
        settle(FL + DL + 28);
        fault_reset_mode_param = 1'b0;
        start_run();
        lag = 3'($urandom % 8);
        open_ch(1'b1, 1'b0);
        {open_a, open_b} = 2'b00;
        tick(FL + DL + 20);
        fault_reset_req = 1'b1;
        tick(1);
        fault_reset_req = 1'b0;
        settle(6);
        open_ch(1'b0, 1'b1);
        {open_a, open_b} = 2'b00;
        tick(FL + DL + 20);
        chk(status, model_status());
        power_cycle();
        start_run();
        lag = 3'($urandom % 8);
        open_ch(1'b0, 1'b1);
        power_cycle();
        start_run();
        // Channel A opens alone and closes again inside the window; auto reset must not clear it.
        fault_reset_mode_param = 1'b1;
        open_a = 1'b1;
        m_run = 0;
        m_fa = 1;
        tick(FL + 6);
        open_a = 1'b0;
        settle(FL + DL + 40);
        tick(8);
        chk(status, model_status());
        fault_reset_mode_param = 1'b0;
        power_cycle();
        start_run();
        end_of_test();
    end
endmodule : testbench
